// >>> rtl/pmsc_top.sv
// power-management status and control: two 8-bit registers over apb
// assumes comparator, stop and interrupt inputs are synchronous to pclk
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pmsc_params.svh"
module pmsc_top
	import pmsc_pkg::*;
(
	input  wire logic        pclk,            // bus clock, 40 mhz
	input  wire logic        presetn,         // async reset, low
	input  wire logic        psel,            // apb select
	input  wire logic        penable,         // apb access phase
	input  wire logic        pwrite,          // apb direction
	input  wire logic [11:0] paddr,           // apb byte address
	input  wire logic [31:0] pwdata,          // apb write data
	output logic      [31:0] prdata,          // apb read data
	output logic             pready,          // apb ready
	output logic             pslverr,         // apb error, unmapped
	input  wire logic        lv_compare,      // comparator: supply below trip
	input  wire logic        in_stop,         // device is in stop mode
	input  wire logic        partial_powerdown_stop_recovered, // pulse on wake from partial_powerdown_stop
	input  wire logic        mcu_irq,         // any active interrupt
	input  wire logic        regulator_ready, // regulator reached standby
	output logic             lv_detect_irq,   // detect interrupt request
	output logic             lv_reset_req,    // force full reset
	output logic             bandgap_buffer_en, // bandgap buffer on
	output logic             lowpower_req_out,  // low-power mode request
	output logic             powerdown_sel_out, // 1 = partial_powerdown_stop, 0 = shallow_stop
	output logic             irq              // combined interrupt
);
	// bus decode
	logic        wr_stb;      // write taken this cycle
	logic        rd_stb;      // read taken this cycle
	logic        sel_lvd;     // first power register addressed
	logic        sel_lpm;     // second power register addressed
	logic        sel_ist;     // interrupt status addressed
	logic        sel_ien;     // interrupt enable addressed
	logic        sel_icl;     // interrupt clear addressed
	logic        mapped;      // any register addressed
	logic        acc_q;       // answer given this cycle

	// first register state
	logic        flag_q;      // low-voltage detect flag
	logic        ie_q;        // detect interrupt enable
	logic        se_q;        // detect stop enable
	logic        bg_q;        // bandgap buffer enable
	logic        re_w;        // reset enable, write-once
	logic        en_w;        // detect enable, write-once

	// second register state
	logic        lpr_q;       // low-power regulator request
	logic        wui_q;       // wake on interrupt
	logic        pdf_q;       // powerdown recovered flag
	logic        pdc_q;       // powerdown select
	logic        pde_w;       // powerdown lockout enable, write-once
	pmsc_reg_state_t rst_q;   // regulator standby tracking
	pmsc_reg_state_t rst_d;

	// interrupt block
	logic [`PMSC_NEV-1:0] ist_q; // sticky event status
	logic [`PMSC_NEV-1:0] ien_q; // event enables
	logic [`PMSC_NEV-1:0] ev;    // event pulses

	// reset pulse stretcher
	logic [3:0]  rcnt_q;      // remaining reset-request cycles

	// derived terms
	logic        detect_live; // detection active right now
	logic        detect_hit;  // qualified detect event
	logic        wr_lvd;      // write to first register
	logic        wr_lpm;      // write to second register
	logic        lvd_ack;     // acknowledge written
	logic        pd_ack;      // recovered-flag acknowledge written
	logic        lpr_wr_set;  // write tries to set request
	logic        pdc_wr_set;  // write tries to set select
	logic        wake_clear;  // interrupt clears the request
	logic        lpr_d;
	logic        pdc_d;
	logic        flag_d;
	logic        pdf_d;
	logic        standby;     // regulator currently in standby
	logic [7:0]  lvd_rd;      // first register read image
	logic [7:0]  lpm_rd;      // second register read image
	logic [31:0] rd_mux;      // selected read word

	// apb decode; one answer per access, given after one wait state
	assign wr_stb  = psel && penable && pwrite && !acc_q;
	assign rd_stb  = psel && penable && !pwrite && !acc_q;
	assign sel_lvd = (paddr == `PMSC_OFF_LVD);
	assign sel_lpm = (paddr == `PMSC_OFF_LPM);
	assign sel_ist = (paddr == `PMSC_OFF_IRQ_ST);
	assign sel_ien = (paddr == `PMSC_OFF_IRQ_EN);
	assign sel_icl = (paddr == `PMSC_OFF_IRQ_CLR);
	assign mapped  = sel_lvd | sel_lpm | sel_ist | sel_ien | sel_icl;
	assign wr_lvd  = wr_stb && sel_lvd;
	assign wr_lpm  = wr_stb && sel_lpm;

	// detection qualified by enable and stop-enable
	assign detect_live = en_w && (!in_stop || se_q);
	assign detect_hit  = detect_live && lv_compare;
	assign lvd_ack     = wr_lvd && pwdata[`PMSC_B_ACK];
	// set wins over acknowledge in the same cycle
	assign flag_d = detect_hit ? 1'b1 : (lvd_ack ? 1'b0 : flag_q);

	// regulator request and powerdown select interlock
	assign lpr_wr_set = wr_lpm && pwdata[`PMSC_B_LPR];
	assign pdc_wr_set = wr_lpm && pwdata[`PMSC_B_PDC];
	assign wake_clear = standby && mcu_irq && wui_q;
	// select settable only with lockout enabled and no request held
	assign pdc_d = wr_lpm ? (pwdata[`PMSC_B_PDC] && pde_w && (pdc_q || !lpr_q))
	                      : pdc_q;
	// request refused while select is set or being set
	assign lpr_d = wake_clear ? 1'b0
	             : wr_lpm ? (pwdata[`PMSC_B_LPR] && !pdc_q && !(pdc_wr_set && pdc_d))
	             : lpr_q;
	assign pd_ack = wr_lpm && pwdata[`PMSC_B_PDACK];
	assign pdf_d  = partial_powerdown_stop_recovered ? 1'b1 : (pd_ack ? 1'b0 : pdf_q);
	assign standby = (rst_q == REG_STANDBY);

	// read images; ack bits and reserved bits read zero
	assign lvd_rd = {flag_q, 1'b0, ie_q, re_w, se_q, en_w, 1'b0, bg_q};
	assign lpm_rd = {lpr_q, standby, wui_q, 1'b0, pdf_q, 1'b0, pde_w, pdc_q};
	assign rd_mux = sel_lvd ? {24'h000000, lvd_rd}
	              : sel_lpm ? {24'h000000, lpm_rd}
	              : sel_ist ? {29'h00000000, ist_q}
	              : sel_ien ? {29'h00000000, ien_q}
	              : 32'h00000000;                             // clear reg is write-only

	// event sources for the sticky status
	assign ev[`PMSC_EV_LVD]  = detect_hit && !flag_q;
	assign ev[`PMSC_EV_PDF]  = partial_powerdown_stop_recovered;
	assign ev[`PMSC_EV_STBY] = (rst_q == REG_ENTER) && regulator_ready;

	// regulator standby tracking: enter on request, leave on drop
	always_comb begin
		rst_d = rst_q;
		case (rst_q)
			REG_RUN:     if (lpr_q) rst_d = REG_ENTER;
			REG_ENTER: begin
				if (!lpr_q) rst_d = REG_RUN;
				else if (regulator_ready) rst_d = REG_STANDBY;
			end
			REG_STANDBY: if (!lpr_q) rst_d = REG_RUN;
			default:     rst_d = REG_RUN;
		endcase
	end

	// write-once bits, one instance per bit
	pmsc_once_bit u_re (
		.pclk    (pclk),
		.presetn (presetn),
		.wr      (wr_lvd),
		.wdata   (pwdata[`PMSC_B_RE]),
		.q       (re_w)
	);
	pmsc_once_bit u_en (
		.pclk    (pclk),
		.presetn (presetn),
		.wr      (wr_lvd),
		.wdata   (pwdata[`PMSC_B_EN]),
		.q       (en_w)
	);
	pmsc_once_bit u_pde (
		.pclk    (pclk),
		.presetn (presetn),
		.wr      (wr_lpm),
		.wdata   (pwdata[`PMSC_B_PDE]),
		.q       (pde_w)
	);

	// bus answer: ready one cycle after access phase starts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q   <= 1'b0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			acc_q   <= psel && penable && !acc_q;
			pready  <= psel && penable && !acc_q;
			pslverr <= psel && penable && !acc_q && !mapped; // unmapped errors
			if (rd_stb) begin
				prdata <= rd_mux;
			end
		end
	end

	// first register; only a real reset clears it, partial_powerdown_stop exit does not
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 1'b0;
			ie_q   <= 1'b0;
			se_q   <= 1'b0;
			bg_q   <= 1'b0;
		end else begin
			flag_q <= flag_d;
			if (wr_lvd) begin
				ie_q <= pwdata[`PMSC_B_IE];
				se_q <= pwdata[`PMSC_B_SE];
				bg_q <= pwdata[`PMSC_B_BG];
			end
		end
	end

	// second register and regulator state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lpr_q <= 1'b0;
			wui_q <= 1'b0;
			pdf_q <= 1'b0;
			pdc_q <= 1'b0;
			rst_q <= REG_RUN;
		end else begin
			lpr_q <= lpr_d;
			pdc_q <= pdc_d;
			pdf_q <= pdf_d;
			rst_q <= rst_d;
			if (wr_lpm) begin
				wui_q <= pwdata[`PMSC_B_WUI];
			end
		end
	end

	// sticky status; a new event beats a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ist_q <= '0;
			ien_q <= '0;
		end else begin
			ist_q <= (ist_q & ~((wr_stb && sel_icl) ? pwdata[`PMSC_NEV-1:0] : '0)) | ev;
			if (wr_stb && sel_ien) begin
				ien_q <= pwdata[`PMSC_NEV-1:0];
			end
		end
	end

	// outputs, all registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lv_detect_irq     <= 1'b0;
			bandgap_buffer_en <= 1'b0;
			lowpower_req_out  <= 1'b0;
			powerdown_sel_out <= 1'b0;
			irq               <= 1'b0;
		end else begin
			lv_detect_irq     <= flag_d && ie_q;
			bandgap_buffer_en <= bg_q;
			lowpower_req_out  <= lpr_d;
			powerdown_sel_out <= pdc_d;
			irq               <= |(ist_q & ien_q);
		end
	end

	// reset request held a few cycles so the reset unit sees it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rcnt_q       <= 4'h0;
			lv_reset_req <= 1'b0;
		end else begin
			if (detect_hit && !flag_q && re_w) begin
				rcnt_q <= `PMSC_RESET_LEN;
			end else if (rcnt_q != 4'h0) begin
				rcnt_q <= rcnt_q - 4'h1;
			end
			lv_reset_req <= (detect_hit && !flag_q && re_w) || (rcnt_q > 4'h1);
		end
	end
endmodule
`default_nettype wire

// >>> rtl/pmsc_params.svh
// constants for the power-management status and control block
// assumes an apb slave with 32-bit data, one register per aligned word
// Overview of operation
// - detect event sets flag while detection enabled
// - ack write one clears flag; reads zero
// - irq enable requests interrupt on flag
// - reset enable forces reset on flag set
// - stop enable keeps detection during stop
// - detect enable gates flag, reset, stop bits
// - write-once bits accept first write only
// - bit 0 enables bandgap reference buffer
// - registers keep contents on partial_powerdown_stop exit
// - regulator request blocked by powerdown select
// - wake-on-interrupt clears regulator request
// - standby status shows regulator in standby
// - wake bit selects interrupt leaves standby
// - recovered flag set after partial_powerdown_stop, ack clears
// - lockout enable gates powerdown select
// - select chooses stop mode; blocked by request
`ifndef PMSC_PARAMS_SVH
`define PMSC_PARAMS_SVH
`define PMSC_OFF_LVD     12'h000
`define PMSC_OFF_LPM     12'h004
`define PMSC_OFF_IRQ_ST  12'h008
`define PMSC_OFF_IRQ_EN  12'h00C
`define PMSC_OFF_IRQ_CLR 12'h010
`define PMSC_B_FLAG      7
`define PMSC_B_ACK       6
`define PMSC_B_IE        5
`define PMSC_B_RE        4
`define PMSC_B_SE        3
`define PMSC_B_EN        2
`define PMSC_B_BG        0
`define PMSC_B_LPR       7
`define PMSC_B_REGULATOR_STANDBY_STATUS      6
`define PMSC_B_WUI       5
`define PMSC_B_PDF       3
`define PMSC_B_PDACK     2
`define PMSC_B_PDE       1
`define PMSC_B_PDC       0
`define PMSC_EV_LVD      0
`define PMSC_EV_PDF      1
`define PMSC_EV_STBY     2
`define PMSC_NEV         3
`define PMSC_RESET_LEN   4'h4
`endif

// >>> rtl/pmsc_pkg.sv
// types shared by the power-management status and control block
// assumes pmsc_params.svh holds the numeric constants
package pmsc_pkg;
	typedef enum logic [1:0] {REG_RUN, REG_ENTER, REG_STANDBY} pmsc_reg_state_t;
endpackage

// >>> rtl/pmsc_once_bit.sv
// write-once control bit: first write after reset sticks
// assumes writes arrive as a one-cycle strobe in the pclk domain
`timescale 1ns/1ps
`default_nettype none
module pmsc_once_bit (
	input  wire logic pclk,    // bus clock
	input  wire logic presetn, // async reset, low
	input  wire logic wr,      // write strobe for this bit
	input  wire logic wdata,   // value written
	output var  logic q        // stored value
);
	logic done_q; // set once the single allowed write is used

	// first write sets both value and lock; later ones ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q      <= 1'b0;
			done_q <= 1'b0;
		end else if (wr && !done_q) begin
			q      <= wdata;
			done_q <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> bench/pmsc_asserts.sv
// port checker for pmsc_top, bound from the bench top file
// assumes one pclk domain and an active-low async reset
`timescale 1ns/1ps
`default_nettype none
module pmsc_asserts (
	input wire logic        pclk,              // bus clock
	input wire logic        presetn,           // reset, low
	input wire logic        psel,              // select
	input wire logic        penable,           // access
	input wire logic        pwrite,            // direction
	input wire logic [11:0] paddr,             // address
	input wire logic [31:0] pwdata,            // write data
	input wire logic [31:0] prdata,            // read data
	input wire logic        pready,            // ready
	input wire logic        pslverr,           // error
	input wire logic        lv_compare,        // comparator
	input wire logic        mcu_irq,           // any interrupt
	input wire logic        lv_reset_req,      // reset request
	input wire logic        bandgap_buffer_en, // buffer on
	input wire logic        lowpower_req_out,  // regulator request
	input wire logic        powerdown_sel_out  // partial_powerdown_stop select
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic acc    = psel && penable && pready;                    // access completes
	wire logic wr4    = psel && penable && pwrite && paddr == 12'h004; // low-power write
	wire logic wr_sel = wr4 && pwdata[0];                             // select asked
	wire logic wr_req = wr4 && pwdata[7] && !pwdata[0];               // request alone
	// one wait state, then a one-cycle answer
	a_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
	a_unmapped_err: assert property (acc |-> pslverr == (paddr > 12'h010)) else $error("pslverr wrong");
	a_ack_reads_zero: assert property (acc && !pwrite && paddr == 12'h000 |-> !prdata[6])
		else $error("ack bit read as one");
	a_bandgap_follows: assert property (acc && pwrite && paddr == 12'h000 |=> bandgap_buffer_en == $past(pwdata[0]))
		else $error("bandgap enable not written");
	// reset request is exactly four cycles long
	a_reset_len: assert property ($rose(lv_reset_req) |-> lv_reset_req [*4] ##1 !lv_reset_req)
		else $error("reset pulse length wrong");
	a_reset_cause: assert property ($rose(lv_reset_req) |-> $past(lv_compare) || $past(lv_compare, 2))
		else $error("reset without comparator");
	a_req_sel_excl: assert property (!(lowpower_req_out && powerdown_sel_out))
		else $error("request and select both set");
	a_sel_cause: assert property ($rose(powerdown_sel_out) |-> $past(wr_sel))
		else $error("select set without write");
	a_req_cause: assert property ($rose(lowpower_req_out) |-> $past(wr_req) && !$past(powerdown_sel_out))
		else $error("request set wrongly");
	// request drops only by a write or an interrupt
	a_req_drop: assert property ($fell(lowpower_req_out) |-> $past(mcu_irq) || $past(wr4))
		else $error("request dropped without cause");
endmodule
`default_nettype wire

// >>> bench/pmsc_top_test.sv
// self-checking bench: register model compared at every read of the two power registers
// assumes pmsc_top and pmsc_asserts are compiled first
`timescale 1ns/1ps
`default_nettype none
module pmsc_top_test;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err; // bus side
	logic [11:0] paddr;                                                      // address
	logic [31:0] pwdata, prdata, rd;                                         // data, captured read
	logic        lv_compare, in_stop, partial_powerdown_stop_recovered, mcu_irq, regulator_ready; // side inputs
	logic        lv_detect_irq, lv_reset_req, bandgap_buffer_en, lowpower_req_out, powerdown_sel_out, irq;
	int          errors, checked, lvd, lpm, lvd_once, lpm_once, r;          // counts and model
	pmsc_top pmsc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.lv_compare(lv_compare), .in_stop(in_stop), .partial_powerdown_stop_recovered(partial_powerdown_stop_recovered), .mcu_irq(mcu_irq),
		.regulator_ready(regulator_ready), .lv_detect_irq(lv_detect_irq), .lv_reset_req(lv_reset_req),
		.bandgap_buffer_en(bandgap_buffer_en), .lowpower_req_out(lowpower_req_out),
		.powerdown_sel_out(powerdown_sel_out), .irq(irq));
	// 40 mhz bus clock
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic final_report;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// compare one result, report a mismatch at once
	task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// one apb transfer; wait for pready is bounded
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			errors++;
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [11:0] a, input int e);
		apb(1'b0, a, 32'h0);
		cmp($sformatf("reg %h", a), e, rd);
		cmp("pslverr", 0, err);
	endtask
	// model of a write; once bits stick after the first write to the register
	task automatic wr(input logic [11:0] a, input int d);
		int pde, pdc;
		apb(1'b1, a, d);
		if (a == 12'h000) begin
			if (d & 'h40) lvd &= 'h7F;
			lvd = (lvd & 'h80) | ((lvd_once ? lvd : d) & 'h14) | (d & 'h29);
			lvd_once = 1;
		end else begin
			pde = (lpm_once ? lpm : d) & 2;
			pdc = ((d & 1) && pde && !(lpm & 'h80)) ? 1 : 0;
			lpm = (lpm & ((d & 4) ? 'h40 : 'h48)) | ((d & 'h80) && !pdc && !(lpm & 1) ? 'h80 : 0) | (d & 'h20) | pde | pdc;
			lpm_once = 1;
		end
		rchk(a, a == 12'h000 ? lvd : lpm);
	endtask
	// main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{lv_compare, in_stop, partial_powerdown_stop_recovered, mcu_irq, regulator_ready} = '0;
		{errors, checked, lvd, lpm, lvd_once, lpm_once} = '0;
		presetn = 1'b0;
		r = $urandom(32'hB3B0);
		cyc(3);
		presetn <= 1'b1;
		rchk(12'h000, 0);
		rchk(12'h004, 0);
		apb(1'b0, 12'hFFC, 32'h0);
		cmp("pslverr unmapped", 1, err);
		wr(12'h000, 'h35);
		wr(12'h000, 'h08);
		repeat (4) begin
			r = $urandom & 'h29;
			wr(12'h000, r);
			cmp("bandgap", r[0], bandgap_buffer_en);
		end
		wr(12'h000, 'h20);
		apb(1'b1, 12'h00C, 32'h1);
		// no detection in stop while stop enable is clear
		in_stop <= 1'b1;
		lv_compare <= 1'b1;
		cyc(8);
		lv_compare <= 1'b0;
		rchk(12'h000, lvd);
		in_stop <= 1'b0;
		lv_compare <= 1'b1;
		cyc(8);
		lv_compare <= 1'b0;
		lvd |= 'h80;
		rchk(12'h000, lvd);
		cmp("detect irq", 1, lv_detect_irq);
		cmp("irq", 1, irq);
		rchk(12'h008, 1);
		apb(1'b1, 12'h00C, 32'h0);
		cyc(2);
		cmp("irq masked", 0, irq);
		apb(1'b1, 12'h00C, 32'h1);
		apb(1'b1, 12'h010, 32'h1);
		cyc(2);
		cmp("irq cleared", 0, irq);
		rchk(12'h008, 0);
		wr(12'h000, 'h60);
		cmp("detect irq", 0, lv_detect_irq);
		wr(12'h004, 'h02);
		wr(12'h004, 'h83);
		cmp("select", 1, powerdown_sel_out);
		wr(12'h004, 'h81);
		wr(12'h004, 'h00);
		wr(12'h004, 'hA2);
		wr(12'h004, 'hA3);
		regulator_ready <= 1'b1;
		cyc(4);
		lpm |= 'h40;
		rchk(12'h004, lpm);
		rchk(12'h008, 4);
		mcu_irq <= 1'b1;
		cyc(4);
		mcu_irq <= 1'b0;
		regulator_ready <= 1'b0;
		cyc(4);
		lpm = 'h22;
		rchk(12'h004, lpm);
		partial_powerdown_stop_recovered <= 1'b1;
		cyc(1);
		partial_powerdown_stop_recovered <= 1'b0;
		cyc(2);
		lpm |= 'h08;
		rchk(12'h004, lpm);
		rchk(12'h000, lvd);
		wr(12'h004, 'h26);
		// second reset in mid-run, then lockout
		presetn <= 1'b0;
		cyc(3);
		presetn <= 1'b1;
		{lvd, lpm, lvd_once, lpm_once} = '0;
		wr(12'h004, 'h01);
		wr(12'h004, 'h03);
		final_report();
	end
endmodule
bind pmsc_top pmsc_asserts pmsc_asserts_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.lv_compare(lv_compare), .mcu_irq(mcu_irq), .lv_reset_req(lv_reset_req),
	.bandgap_buffer_en(bandgap_buffer_en), .lowpower_req_out(lowpower_req_out),
	.powerdown_sel_out(powerdown_sel_out));
`default_nettype wire
